/* rtl/ipdc_arbiter.v */
// Priority selection among pending sources with a non-zero level.
`timescale 1ns/1ps
`default_nettype none

module ipdc_arbiter #(
    parameter N = 88,
    parameter IW = 7
) (
    input wire [N-1:0] req,
    input wire [4*N-1:0] lvl,
    output reg best_v,
    output reg [IW-1:0] best_i,
    output reg [3:0] best_l
);

integer i;

// A strict compare keeps the lowest index on a tie, which is the fixed
// default order; starting from level 0 drops level-0 sources entirely.
always @*
begin
    best_v = 1'b0;
    best_i = {IW{1'b0}};
    best_l = 4'h0;
    for (i = 0; i < N; i = i + 1)
    begin
        if (req[i] && (lvl[4*i +: 4] > best_l))
        begin
            best_v = 1'b1;
            best_i = i[IW-1:0];
            best_l = lvl[4*i +: 4];
        end
    end
end

endmodule // ipdc_arbiter

`default_nettype wire

/* rtl/ipdc_map.vh */
// Register offsets, field positions, reset values and encodings of the priority block.
`ifndef IPDC_MAP_VH
`define IPDC_MAP_VH

// ----------------------------------------------------------------------
// Register word indices on the plain register port
// ----------------------------------------------------------------------
`define IPDC_ADDR_W 4
`define IPDC_OFS_PRIO_A 4'h0
`define IPDC_OFS_PRIO_L 4'hB
`define IPDC_OFS_CTRL 4'hC
`define IPDC_OFS_STAT 4'hD
`define IPDC_OFS_MASK 4'hE

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define IPDC_NUM_PRIO 12
`define IPDC_NUM_EXT 8
`define IPDC_FIELD_W 4
`define IPDC_FIELDS_PER_REG 4
`define IPDC_REG_W 16

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define IPDC_CTRL_PIN_LEVEL_BIT 15
`define IPDC_CTRL_EDGE_SEL_BIT 8
`define IPDC_CTRL_WR_MASK 16'h01FF
`define IPDC_CTRL_RST 9'h000
`define IPDC_PRIO_RST 16'h0000

// ----------------------------------------------------------------------
// Event status and mask layout
// ----------------------------------------------------------------------
`define IPDC_STAT_W 10
`define IPDC_STAT_NMI_BIT 8
`define IPDC_STAT_ACC_BIT 9
`define IPDC_STAT_RST 10'h000

// ----------------------------------------------------------------------
// Vector numbering, values arbitrary
// ----------------------------------------------------------------------
`define IPDC_NMI_VEC 8'h0B
`define IPDC_EXT_VEC_BASE 8'h40
`define IPDC_PER_VEC_BASE 8'h48
`define IPDC_LEVEL_MAX 4'hF

`endif

/* rtl/ipdc_sync.v */
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none

module ipdc_sync #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire rst,
    input wire [W-1:0] async_in,
    input wire [W-1:0] rst_val,
    output reg [W-1:0] sync_out
);

reg [W-1:0] meta_q;

// The reset value is a strap-free constant supplied by the instantiator.
always @(posedge sys_clk)
begin
    if (rst)
    begin
        meta_q <= rst_val;
        sync_out <= rst_val;
    end
    else
    begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end
end

endmodule // ipdc_sync

`default_nettype wire

/* rtl/ipdc_top.v */
// Interrupt priority configuration, pin sensing and arbitration toward the core.
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_map.vh"

module ipdc_top #(
    parameter NUM_PERIPH = 80
) (
    input wire sys_clk,
    input wire rst,
    input wire hw_standby,
    input wire [`IPDC_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire nmi_pin,
    input wire [7:0] ext_req_pins_n,
    input wire [NUM_PERIPH-1:0] periph_req,
    input wire [3:0] cpu_mask_level,
    input wire cpu_int_ack,
    output reg cpu_int_req,
    output reg cpu_nmi_req,
    output reg [3:0] cpu_int_level,
    output reg [7:0] cpu_int_vector,
    output reg int_accepted_out_n,
    output reg irq_out
);

// ----------------------------------------------------------------------
// Local sizes
// ----------------------------------------------------------------------
localparam NE = `IPDC_NUM_EXT;
localparam NS = NE + NUM_PERIPH;
localparam IW = 7;
localparam PW = `IPDC_NUM_PRIO * `IPDC_REG_W;

// ----------------------------------------------------------------------
// Storage
// ----------------------------------------------------------------------
reg [PW-1:0] prio_q;
reg [8:0] ctrl_q;
reg [`IPDC_STAT_W-1:0] stat_q;
reg [`IPDC_STAT_W-1:0] mask_q;
reg nmi_prev_q;
reg nmi_pend_q;
reg [NE-1:0] ext_prev_q;
reg [NE-1:0] edge_pend_q;
reg [IW-1:0] pres_idx_q;
reg pres_valid_q;
wire clr_all;
wire nmi_s;
wire [NE-1:0] ext_s;
wire nmi_edge;
wire [NE-1:0] ext_fall;
wire [NE-1:0] ext_sense;
wire [NE-1:0] ext_req;
wire [NS-1:0] all_req;
wire [4*NS-1:0] all_lvl;
wire best_v;
wire [IW-1:0] best_i;
wire [3:0] best_l;
wire accept_now;
wire [IW-1:0] per_idx;
wire ack_ext;
wire ack_nmi;
wire [`IPDC_STAT_W-1:0] stat_set;
wire [`IPDC_STAT_W-1:0] stat_clr;
reg [7:0] vec_d;
integer r;
integer w;

// Hardware standby clears the same state as reset except the pin synchronisers, the read port
// and the edge history, which takes the synchronised pin level; software standby does not reach this block at all, so contents survive it.
assign clr_all = rst | hw_standby;

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
ipdc_sync #(
    .W(1)
) u_nmi_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(nmi_pin),
    .rst_val(1'b1),
    .sync_out(nmi_s)
);

ipdc_sync #(
    .W(NE)
) u_ext_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(ext_req_pins_n),
    .rst_val({NE{1'b1}}),
    .sync_out(ext_s)
);

// ----------------------------------------------------------------------
// Non-maskable edge detection
// ----------------------------------------------------------------------
assign nmi_edge = ctrl_q[`IPDC_CTRL_EDGE_SEL_BIT] ?
                  (~nmi_prev_q & nmi_s) :
                  (nmi_prev_q & ~nmi_s);

// ----------------------------------------------------------------------
// External request sensing, one slice per pin
// ----------------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < NE; g = g + 1)
    begin : g_ext
        assign ext_sense[g] = ctrl_q[NE-1-g];
        assign ext_fall[g] = ext_prev_q[g] & ~ext_s[g];
        // Level mode follows the pin; edge mode holds until acknowledged.
        assign ext_req[g] = ext_sense[g] ? edge_pend_q[g] : ~ext_s[g];
        // Pin g takes field g: register A then B, MSB field first.
        assign all_lvl[4*g +: 4] =
            prio_q[(g/4)*16 + (3-(g%4))*4 +: 4];
    end
endgenerate

// ----------------------------------------------------------------------
// Peripheral levels; each field serves two adjacent sources
// ----------------------------------------------------------------------
generate
    for (g = 0; g < NUM_PERIPH; g = g + 1)
    begin : g_per
        // Peripheral pair p uses field 8+p, so K and L land on their
        // serial, CAN and watchdog groups in MSB-first order.
        assign all_lvl[4*(NE+g) +: 4] =
            prio_q[((NE+g/2)/4)*16 + (3-((NE+g/2)%4))*4 +: 4];
    end
endgenerate

assign all_req = {periph_req, ext_req};

// ----------------------------------------------------------------------
// Arbitration
// ----------------------------------------------------------------------
ipdc_arbiter #(
    .N(NS),
    .IW(IW)
) u_arb (
    .req(all_req),
    .lvl(all_lvl),
    .best_v(best_v),
    .best_i(best_i),
    .best_l(best_l)
);

// Levels compare as plain unsigned numbers, so F is the top level.
assign accept_now = best_v && (best_l > cpu_mask_level);
assign per_idx = best_i - NE[IW-1:0];

always @*
begin
    if (best_i < NE[IW-1:0])
        vec_d = `IPDC_EXT_VEC_BASE + {1'b0, best_i};
    else
        vec_d = `IPDC_PER_VEC_BASE + {1'b0, per_idx};
end

// An acknowledge applies to whatever is presented to the core in the cycle the acknowledge arrives.
// An edge request that lost to a higher one keeps its flag, since only
// the presented pin is cleared.
assign ack_nmi = cpu_int_ack & cpu_nmi_req;
assign ack_ext = cpu_int_ack & ~cpu_nmi_req & pres_valid_q &
                 (pres_idx_q < NE[IW-1:0]);

// ----------------------------------------------------------------------
// Request state
// ----------------------------------------------------------------------
always @(posedge sys_clk)
begin
    if (clr_all)
    begin
        // Standby leaves the synchronisers running, so the edge history
        // takes the level it sees; a pin already low on leaving standby
        // must not count as a fresh edge.
        nmi_prev_q <= rst | nmi_s;
        nmi_pend_q <= 1'b0;
        ext_prev_q <= ext_s | {NE{rst}};
        edge_pend_q <= {NE{1'b0}};
    end
    else
    begin
        nmi_prev_q <= nmi_s;
        ext_prev_q <= ext_s;
        // A new edge in the acknowledge cycle wins over the clear.
        nmi_pend_q <= nmi_edge | (nmi_pend_q & ~ack_nmi);
        for (r = 0; r < NE; r = r + 1)
        begin
            if (ext_sense[r] && ext_fall[r])
                edge_pend_q[r] <= 1'b1;
            else if (ack_ext && (pres_idx_q == r[IW-1:0]))
                edge_pend_q[r] <= 1'b0;
            else if (!ext_sense[r])
                edge_pend_q[r] <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// Outputs toward the core
// ----------------------------------------------------------------------
always @(posedge sys_clk)
begin
    if (clr_all)
    begin
        cpu_int_req <= 1'b0;
        cpu_nmi_req <= 1'b0;
        cpu_int_level <= 4'h0;
        cpu_int_vector <= 8'h00;
        int_accepted_out_n <= 1'b1;
        pres_idx_q <= {IW{1'b0}};
        pres_valid_q <= 1'b0;
    end
    else
    begin
        cpu_nmi_req <= nmi_pend_q & ~ack_nmi;
        pres_valid_q <= accept_now;
        pres_idx_q <= best_i;
        if (nmi_pend_q && !ack_nmi)
        begin
            // The non-maskable request outranks every mask level.
            cpu_int_req <= 1'b1;
            cpu_int_level <= `IPDC_LEVEL_MAX;
            cpu_int_vector <= `IPDC_NMI_VEC;
        end
        else
        begin
            cpu_int_req <= accept_now;
            cpu_int_level <= accept_now ? best_l : 4'h0;
            cpu_int_vector <= accept_now ? vec_d : 8'h00;
        end
        int_accepted_out_n <= ~(accept_now | (nmi_pend_q & ~ack_nmi));
    end
end

// ----------------------------------------------------------------------
// Event status and interrupt line
// ----------------------------------------------------------------------
assign stat_set = {accept_now & ~pres_valid_q, nmi_edge,
                   ext_fall[0], ext_fall[1], ext_fall[2], ext_fall[3],
                   ext_fall[4], ext_fall[5], ext_fall[6], ext_fall[7]};
assign stat_clr = (reg_wr && reg_addr == `IPDC_OFS_STAT) ?
                  reg_wdata[`IPDC_STAT_W-1:0] : {`IPDC_STAT_W{1'b0}};

always @(posedge sys_clk)
begin
    if (clr_all)
    begin
        stat_q <= `IPDC_STAT_RST;
        mask_q <= `IPDC_STAT_RST;
        irq_out <= 1'b0;
    end
    else
    begin
        // Set wins over a same-cycle write-one clear.
        stat_q <= (stat_q & ~stat_clr) | stat_set;
        if (reg_wr && reg_addr == `IPDC_OFS_MASK)
            mask_q <= reg_wdata[`IPDC_STAT_W-1:0];
        irq_out <= |(stat_q & mask_q);
    end
end

// ----------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------
always @(posedge sys_clk)
begin
    if (clr_all)
    begin
        prio_q <= {`IPDC_NUM_PRIO{`IPDC_PRIO_RST}};
        ctrl_q <= `IPDC_CTRL_RST;
    end
    else if (reg_wr)
    begin
        // Own loop index, so that no variable is driven from two processes.
        for (w = 0; w < `IPDC_NUM_PRIO; w = w + 1)
        begin
            if (reg_addr == w[`IPDC_ADDR_W-1:0])
                prio_q[16*w +: 16] <= reg_wdata;
        end
        // Only bits 8..0 are stored; pin level and reserved bits ignore writes.
        if (reg_addr == `IPDC_OFS_CTRL)
            ctrl_q <= reg_wdata[8:0];
    end
end

// ----------------------------------------------------------------------
// Register reads, data valid the cycle after the strobe
// ----------------------------------------------------------------------
always @(posedge sys_clk)
begin
    // Only reset clears the read port; standby leaves it alone, as the
    // word falls back to zero one cycle after any read anyway.
    if (rst)
        reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
        if (reg_addr <= `IPDC_OFS_PRIO_L)
            reg_rdata <= prio_q[16*reg_addr +: 16];
        else if (reg_addr == `IPDC_OFS_CTRL)
            reg_rdata <= {nmi_s, 6'h00, ctrl_q};
        else if (reg_addr == `IPDC_OFS_STAT)
            reg_rdata <= {6'h00, stat_q};
        else if (reg_addr == `IPDC_OFS_MASK)
            reg_rdata <= {6'h00, mask_q};
        else
            reg_rdata <= 16'h0000;
    end
    else
        reg_rdata <= 16'h0000;
end

endmodule // ipdc_top

`default_nettype wire

/* testbench/interrupt_priority_detect_config_test.sv */
// Self-checking bench for the interrupt priority block.
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_map.vh"
module interrupt_priority_detect_config_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_standby = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nmi_pin = 1'b1;
    logic [7:0] ext_req_pins_n = 8'hFF;
    logic [79:0] periph_req = 80'h0;
    logic [3:0] mask_in = 4'h0;
    logic ack_en = 1'b0;
    logic [3:0] ack_wait = 4'h0;
    wire [15:0] reg_rdata;
    wire [3:0] cpu_mask_level;
    wire cpu_int_ack, cpu_int_req, cpu_nmi_req, int_accepted_out_n, irq_out;
    wire [3:0] cpu_int_level;
    wire [7:0] cpu_int_vector;
    wire [15:0] core_view = {cpu_int_req, cpu_nmi_req, int_accepted_out_n,
        cpu_int_level, cpu_int_vector, 1'b0};
    int n_errors = 0;
    int checks = 0;
    always #10 sys_clk = ~sys_clk;
    ipdc_top #(.NUM_PERIPH(80)) dut (.sys_clk(sys_clk), .rst(rst),
        .hw_standby(hw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nmi_pin(nmi_pin), .ext_req_pins_n(ext_req_pins_n),
        .periph_req(periph_req), .cpu_mask_level(cpu_mask_level),
        .cpu_int_ack(cpu_int_ack), .cpu_int_req(cpu_int_req),
        .cpu_nmi_req(cpu_nmi_req), .cpu_int_level(cpu_int_level),
        .cpu_int_vector(cpu_int_vector),
        .int_accepted_out_n(int_accepted_out_n), .irq_out(irq_out));
    ipdc_core_model core (.sys_clk(sys_clk), .rst(rst), .int_req(cpu_int_req),
        .mask_in(mask_in), .ack_en(ack_en), .ack_wait(ack_wait),
        .mask_level(cpu_mask_level), .int_ack(cpu_int_ack));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Each bus task ends on a clock edge, with one idle edge after a write.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
        @(posedge sys_clk);
    endtask
    task automatic expect_req(input logic r, input logic n,
        input logic [3:0] l, input logic [7:0] v);
        logic [15:0] e;
        e = {r, n, !r, l, v, 1'b0};
        // Look only once the launching edge has settled.
        #1;
        for (int i = 0; i < 10 && core_view !== e; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        check(core_view, e);
        @(posedge sys_clk);
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge sys_clk);
        #1 check({15'h0000, irq_out}, {15'h0000, e});
        @(posedge sys_clk);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 12; i++) rd(4'(i), 16'h0000);
        rd(`IPDC_OFS_CTRL, 16'h8000);
        for (int i = 0; i < 12; i++) wr(4'(i), 16'h1357 + 16'(i));
        for (int i = 0; i < 12; i++) rd(4'(i), 16'h1357 + 16'(i));
        wr(`IPDC_OFS_CTRL, 16'h01FF);
        rd(`IPDC_OFS_CTRL, 16'h81FF);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        hw_standby <= 1'b1;
        @(posedge sys_clk);
        hw_standby <= 1'b0;
        @(posedge sys_clk);
        rd(4'h5, 16'h0000);
        rd(`IPDC_OFS_CTRL, 16'h8000);
    endtask
    task automatic t_periph;
        wr(`IPDC_OFS_PRIO_L, 16'h1234);
        periph_req[79:72] <= 8'hD5;
        expect_req(1'b1, 1'b0, 4'h4, 8'h96);
        periph_req[79:72] <= 8'h95;
        expect_req(1'b1, 1'b0, 4'h4, 8'h97);
        periph_req[79:72] <= 8'h15;
        expect_req(1'b1, 1'b0, 4'h3, 8'h94);
        mask_in <= 4'h3;
        expect_req(1'b0, 1'b0, 4'h0, 8'h00);
        mask_in <= 4'h2;
        expect_req(1'b1, 1'b0, 4'h3, 8'h94);
        mask_in <= 4'h0;
        wr(`IPDC_OFS_PRIO_L, 16'h1204);
        expect_req(1'b1, 1'b0, 4'h2, 8'h92);
        wr(`IPDC_OFS_PRIO_L, 16'h0000);
        expect_req(1'b0, 1'b0, 4'h0, 8'h00);
        periph_req <= 80'h0;
    endtask
    task automatic t_ext;
        wr(`IPDC_OFS_PRIO_A, 16'h5600);
        wr(`IPDC_OFS_CTRL, 16'h0040);
        wr(`IPDC_OFS_MASK, 16'h0040);
        ext_req_pins_n <= 8'hFE;
        expect_req(1'b1, 1'b0, 4'h5, 8'h40);
        ext_req_pins_n <= 8'hFF;
        expect_req(1'b0, 1'b0, 4'h0, 8'h00);
        ext_req_pins_n <= 8'hFD;
        repeat (2) @(posedge sys_clk);
        ext_req_pins_n <= 8'hFF;
        expect_req(1'b1, 1'b0, 4'h6, 8'h41);
        repeat (4) @(posedge sys_clk);
        expect_req(1'b1, 1'b0, 4'h6, 8'h41);
        rd(`IPDC_OFS_STAT, 16'h02C0);
        rd(`IPDC_OFS_MASK, 16'h0040);
        chk_irq(1'b1);
        wr(`IPDC_OFS_MASK, 16'h0000);
        chk_irq(1'b0);
        wr(`IPDC_OFS_MASK, 16'h0040);
        chk_irq(1'b1);
        wr(`IPDC_OFS_STAT, 16'h0040);
        chk_irq(1'b0);
        rd(`IPDC_OFS_STAT, 16'h0280);
        ack_wait <= 4'h3;
        ack_en <= 1'b1;
        expect_req(1'b0, 1'b0, 4'h0, 8'h00);
        ack_en <= 1'b0;
    endtask
    task automatic t_nmi;
        wr(`IPDC_OFS_MASK, 16'h0100);
        mask_in <= 4'hF;
        nmi_pin <= 1'b0;
        expect_req(1'b1, 1'b1, 4'hF, 8'h0B);
        chk_irq(1'b1);
        ack_wait <= 4'h0;
        ack_en <= 1'b1;
        expect_req(1'b0, 1'b0, 4'h0, 8'h00);
        ack_en <= 1'b0;
        wr(`IPDC_OFS_STAT, 16'h0100);
        chk_irq(1'b0);
        wr(`IPDC_OFS_CTRL, 16'h8100);
        rd(`IPDC_OFS_CTRL, 16'h0100);
        nmi_pin <= 1'b1;
        expect_req(1'b1, 1'b1, 4'hF, 8'h0B);
        ack_en <= 1'b1;
        expect_req(1'b0, 1'b0, 4'h0, 8'h00);
        ack_en <= 1'b0;
    endtask
    task automatic conclude;
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_errors++;
        conclude;
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs;
        t_periph;
        t_ext;
        t_nmi;
        conclude;
    end
endmodule // interrupt_priority_detect_config_test
`default_nettype wire

/* testbench/ipdc_core_model.sv */
// Processor core model: holds the mask level and acknowledges requests.
`timescale 1ns/1ps
`default_nettype none
module ipdc_core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic int_req,
    input wire logic [3:0] mask_in,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    output logic [3:0] mask_level,
    output logic int_ack
);
    logic [3:0] cnt_q;
    logic armed_q;
    logic ack_q = 1'b0;
    assign mask_level = mask_in;
    assign int_ack = ack_q;
    // One acknowledge per request; re-armed once the request drops, ack_en is low or reset is high.
    always @(posedge sys_clk)
    begin
        ack_q <= 1'b0;
        if (rst || !int_req || !ack_en)
        begin
            cnt_q <= 4'h0;
            armed_q <= 1'b1;
        end
        else if (armed_q && cnt_q == ack_wait)
        begin
            ack_q <= 1'b1;
            armed_q <= 1'b0;
        end
        else if (armed_q)
            cnt_q <= cnt_q + 4'h1;
    end
endmodule // ipdc_core_model
`default_nettype wire

/* testbench/ipdc_top_assertions.sv */
// Concurrent checks on the ports of the interrupt priority block.
`timescale 1ns/1ps
`default_nettype none
`include "ipdc_map.vh"
module ipdc_top_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hw_standby,
    input wire logic [`IPDC_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic nmi_pin,
    input wire logic [3:0] cpu_mask_level,
    input wire logic cpu_int_req,
    input wire logic cpu_nmi_req,
    input wire logic [3:0] cpu_int_level,
    input wire logic [7:0] cpu_int_vector,
    input wire logic int_accepted_out_n,
    input wire logic irq_out
);
    logic [2:0] stab_q;
    logic nmi_prev_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff rst;
    // The pin passes a synchroniser, so its level is only judged once quiet.
    always @(posedge sys_clk)
    begin
        nmi_prev_q <= nmi_pin;
        if (rst || hw_standby || nmi_pin != nmi_prev_q)
            stab_q <= 3'h0;
        else if (stab_q != 3'h7)
            stab_q <= stab_q + 3'h1;
    end
    a_nmi_level_read: assert property (
        reg_rd && reg_addr == `IPDC_OFS_CTRL && stab_q >= 3'h4
        |=> reg_rdata[15] == $past(nmi_pin))
        else $error("control bit 15 differs from pin level");
    a_ctrl_reserved_zero: assert property (
        reg_rd && reg_addr == `IPDC_OFS_CTRL |=> reg_rdata[14:9] == 6'h00)
        else $error("control bits 14 to 9 not zero");
    a_mask_gate: assert property (
        cpu_int_req && !cpu_nmi_req |->
        cpu_int_level > $past(cpu_mask_level))
        else $error("request presented at or below mask");
    a_level_nonzero: assert property (
        cpu_int_req |-> cpu_int_level != 4'h0)
        else $error("level zero request forwarded");
    a_accept_pin_low: assert property (
        cpu_int_req == !int_accepted_out_n)
        else $error("accepted pin disagrees with request");
    a_nmi_vector: assert property (
        cpu_nmi_req |-> cpu_int_req && cpu_int_level == `IPDC_LEVEL_MAX
        && cpu_int_vector == `IPDC_NMI_VEC)
        else $error("non-maskable request with wrong level or vector");
    a_idle_quiet: assert property (
        !cpu_int_req |-> cpu_int_level == 4'h0 && cpu_int_vector == 8'h00)
        else $error("level or vector shown with no request");
    a_standby_clears: assert property (
        hw_standby |=> !cpu_int_req && int_accepted_out_n && !irq_out)
        else $error("outputs not cleared by standby");
    c_maskable: cover property (cpu_int_req && !cpu_nmi_req);
    c_nmi: cover property (cpu_nmi_req);
    c_irq: cover property (irq_out);
endmodule // ipdc_top_assertions
bind ipdc_top ipdc_top_assertions u_chk (.sys_clk(sys_clk), .rst(rst),
    .hw_standby(hw_standby), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
    .cpu_mask_level(cpu_mask_level), .cpu_int_req(cpu_int_req),
    .cpu_nmi_req(cpu_nmi_req), .cpu_int_level(cpu_int_level),
    .cpu_int_vector(cpu_int_vector),
    .int_accepted_out_n(int_accepted_out_n), .irq_out(irq_out));
`default_nettype wire
